// *** design/sdl_pkg.sv ***
package sdl_pkg;
  // Chain length and the longest allowed clock-high phase
  localparam int unsigned SDL_DEPTH        = 1024;
  localparam int unsigned SDL_CLK_HI_MAX_US = 100;
  localparam int unsigned SDL_SYS_MHZ      = 20;
  localparam int unsigned SDL_CLK_HI_MAX_CYC =
    SDL_CLK_HI_MAX_US * SDL_SYS_MHZ;
  localparam logic        SDL_OUT_RST      = 1'b0;
endpackage

// *** design/sdl_edge_det.sv ***
`timescale 1ns/10ps
module sdl_edge_det (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Sampled shift clock level
  input  wire logic level_i,
  // Falling-edge strobe
  output logic      fall_o
);
  logic level_r;
  logic level_nxt;
  logic fall_r;
  logic fall_nxt;

  always_comb begin
    level_nxt = level_i;
    fall_nxt  = level_r & ~level_i;
  end

  // Level tracks the pin through reset, so release neither invents
  // nor loses a falling edge
  always_ff @(posedge clk_i) begin
    level_r <= level_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fall_r <= 1'b0;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  assign fall_o = fall_r;
endmodule

// *** design/sdl_delay_line.sv ***
`timescale 1ns/10ps
module sdl_delay_line
  import sdl_pkg::*;
#(
  parameter int unsigned DEPTH = sdl_pkg::SDL_DEPTH
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Shift clock and input selection
  input  wire logic shift_clk_i,
  input  wire logic select_i,
  // Serial data
  input  wire logic serial_in_primary_i,
  input  wire logic serial_in_alternate_i,
  output logic      serial_out_o,
  // High phase ran past its limit
  output logic      clk_hi_over_o
);
  import sdl_pkg::*;

  localparam int unsigned CW = $clog2(SDL_CLK_HI_MAX_CYC + 2);
  // Counter parks one past the limit so it never wraps back to quiet
  localparam logic [CW-1:0] HI_SAT = CW'(SDL_CLK_HI_MAX_CYC + 1);

  // Shared by the shift path and its check
  function automatic logic pick_bit(
    input logic sel,
    input logic pri,
    input logic alt
  );
    return sel ? alt : pri;
  endfunction

  function automatic logic over_limit(input logic [CW-1:0] cnt);
    return cnt > CW'(SDL_CLK_HI_MAX_CYC);
  endfunction

  logic             fall;
  logic             sel_d_r;
  logic             sel_d_nxt;
  logic             pri_d_r;
  logic             pri_d_nxt;
  logic             alt_d_r;
  logic             alt_d_nxt;
  logic [DEPTH-1:0] chain_r;
  logic [DEPTH-1:0] chain_nxt;
  logic             out_r;
  logic             out_nxt;
  logic [CW-1:0]    hi_cnt_r;
  logic [CW-1:0]    hi_cnt_nxt;
  logic             over_r;
  logic             over_nxt;

  // Detector adds one cycle; data is delayed to match so the sample
  // is the one present at the falling edge itself
  sdl_edge_det u_edge (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i (shift_clk_i),
    .fall_o  (fall)
  );

  always_comb begin
    sel_d_nxt = select_i;
    pri_d_nxt = serial_in_primary_i;
    alt_d_nxt = serial_in_alternate_i;
    chain_nxt = chain_r;
    out_nxt   = out_r;
    if (fall) begin
      chain_nxt = {chain_r[DEPTH-2:0],
                   pick_bit(sel_d_r, pri_d_r, alt_d_r)};
      out_nxt   = chain_r[DEPTH-1];
    end
    // No fall means no change, however long the clock rests low
  end

  // Watch only; the far side owns the limit on high time
  always_comb begin
    hi_cnt_nxt = '0;
    over_nxt   = over_r;
    if (shift_clk_i) begin
      hi_cnt_nxt = (hi_cnt_r == HI_SAT) ?
                   hi_cnt_r : hi_cnt_r + 1'b1;
    end
    if (over_limit(hi_cnt_r)) begin
      over_nxt = 1'b1;
    end
  end

  // Chain carries no reset: storage content is undefined at power-up
  always_ff @(posedge clk_i) begin
    chain_r <= chain_nxt;
    sel_d_r <= sel_d_nxt;
    pri_d_r <= pri_d_nxt;
    alt_d_r <= alt_d_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_r    <= SDL_OUT_RST;
      hi_cnt_r <= '0;
      over_r   <= 1'b0;
    end else begin
      out_r    <= out_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      over_r   <= over_nxt;
    end
  end

  assign serial_out_o  = out_r;
  assign clk_hi_over_o = over_r;

  // Case equality: stages hold unknowns until the chain has filled
  property p_shift_out;
    @(posedge clk_i) disable iff (srst_i)
      fall |=> (serial_out_o === $past(chain_r[DEPTH-1]));
  endproperty
  a_shift_out: assert property (p_shift_out)
    else $error("output did not take last stage on fall");

  property p_capture;
    @(posedge clk_i) disable iff (srst_i)
      fall |=> (chain_r[0] ===
        pick_bit($past(sel_d_r), $past(pri_d_r), $past(alt_d_r)));
  endproperty
  a_capture: assert property (p_capture)
    else $error("first stage took wrong input");

  property p_advance;
    @(posedge clk_i) disable iff (srst_i)
      fall |=> (chain_r[DEPTH-1:1] === $past(chain_r[DEPTH-2:0]));
  endproperty
  a_advance: assert property (p_advance)
    else $error("chain did not advance one stage");

  property p_hold;
    @(posedge clk_i) disable iff (srst_i)
      !fall |=> ((chain_r === $past(chain_r)) &&
                 (serial_out_o === $past(serial_out_o)));
  endproperty
  a_hold: assert property (p_hold)
    else $error("chain changed without falling edge");

  property p_fall_once;
    @(posedge clk_i) disable iff (srst_i)
      fall |=> !fall;
  endproperty
  a_fall_once: assert property (p_fall_once)
    else $error("falling strobe lasted two cycles");

  property p_fall_cause;
    @(posedge clk_i) disable iff (srst_i)
      fall |-> ($past(shift_clk_i, 2) && !$past(shift_clk_i));
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("falling strobe without a falling shift clock");

  property p_fall_src;
    @(posedge clk_i) disable iff (srst_i)
      $fell(shift_clk_i) |=> fall;
  endproperty
  a_fall_src: assert property (p_fall_src)
    else $error("falling shift clock missed");

  property p_over;
    @(posedge clk_i) disable iff (srst_i)
      over_limit(hi_cnt_r) |=> clk_hi_over_o;
  endproperty
  a_over: assert property (p_over)
    else $error("long high phase not flagged");

  property p_cnt_clear;
    @(posedge clk_i) disable iff (srst_i)
      !shift_clk_i |=> (hi_cnt_r == '0);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("high-time count not cleared by low clock");

  property p_cnt_step;
    @(posedge clk_i) disable iff (srst_i)
      (shift_clk_i && (hi_cnt_r != HI_SAT)) |=>
        (hi_cnt_r == $past(hi_cnt_r) + 1'b1);
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("high-time count did not step by one");

  property p_cnt_sat;
    @(posedge clk_i) disable iff (srst_i)
      (shift_clk_i && (hi_cnt_r == HI_SAT)) |=> (hi_cnt_r == HI_SAT);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat)
    else $error("high-time count left its parking value");

  property p_over_stick;
    @(posedge clk_i) disable iff (srst_i)
      clk_hi_over_o |=> clk_hi_over_o;
  endproperty
  a_over_stick: assert property (p_over_stick)
    else $error("over-limit flag cleared without reset");

  property p_over_quiet;
    @(posedge clk_i) disable iff (srst_i)
      (!clk_hi_over_o && !over_limit(hi_cnt_r)) |=> !clk_hi_over_o;
  endproperty
  a_over_quiet: assert property (p_over_quiet)
    else $error("over-limit flag set inside the allowed high time");

  property p_over_cause;
    @(posedge clk_i) disable iff (srst_i)
      $rose(clk_hi_over_o) |-> $past(shift_clk_i, 2);
  endproperty
  a_over_cause: assert property (p_over_cause)
    else $error("over-limit flag rose without a high shift clock");
endmodule

// *** tb/sdl_far.sv ***
`timescale 1ns/10ps
module sdl_far (
  // Chain output and looped-back alternate input
  input  wire logic serial_out_i,
  output logic      alt_o
);
  // Plain wire loop, no gating
  assign alt_o = serial_out_i;
endmodule

// *** tb/test_serial_delay_line_1024.sv ***
`timescale 1ns/10ps
module test_serial_delay_line_1024;
  import sdl_pkg::*;
  // Short chain keeps the run brief
  localparam int unsigned D = 8;
  logic clk_i  = 1'b0;
  logic srst_i = 1'b1;
  logic sck    = 1'b0;
  logic sel    = 1'b0;
  logic din    = 1'b0;
  logic alt;
  logic dout;
  logic over;
  logic q[$];
  int   n_fail      = 0;
  int   comparisons = 0;

  initial forever #25 clk_i = ~clk_i;

  sdl_delay_line #(.DEPTH(D)) sdl_delay_line_inst (
    .clk_i(clk_i), .srst_i(srst_i), .shift_clk_i(sck), .select_i(sel),
    .serial_in_primary_i(din), .serial_in_alternate_i(alt),
    .serial_out_o(dout), .clk_hi_over_o(over));
  sdl_far sdl_far_inst (.serial_out_i(dout), .alt_o(alt));

  task check(string what, logic seen, logic exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %b seen %b", what, exp, seen);
    end
  endtask

  task wrap_up;
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One shift-clock pulse, high for hi cycles; alternate needs full chain
  task shift(logic s, logic b, int hi);
    logic e;
    e = s ? q[q.size()-1-D] : b;
    @(posedge clk_i);
    sel <= s;
    din <= b;
    sck <= 1'b1;
    repeat (hi) @(posedge clk_i);
    sck <= 1'b0;
    repeat (3) @(posedge clk_i);
    q.push_back(e);
    #1;
    if (q.size() > D) check("out", dout, q[q.size()-1-D]);
  endtask

  task t_fill;
    for (int i = 0; i < 3 * D; i++) shift(1'b0, i[0] ^ i[2], 2);
    $display("fill done");
  endtask

  // Data input driven opposite to the looped bit
  task t_recirc;
    for (int i = 0; i < 2 * D; i++) begin
      shift(1'b1, ~q[q.size()-1-D], 2);
    end
    $display("recirculate done");
  endtask

  task t_rest;
    repeat (3000) @(posedge clk_i);
    #1 check("rest", dout, q[q.size()-1-D]);
    for (int i = 0; i < D; i++) shift(1'b0, i[1], 2);
    $display("rest done");
  endtask

  // High exactly at the limit stays quiet; beyond it the flag rises
  task t_over;
    check("over low", over, 1'b0);
    shift(1'b0, 1'b1, SDL_CLK_HI_MAX_CYC);
    check("over edge", over, 1'b0);
    @(posedge clk_i);
    sck <= 1'b1;
    repeat (SDL_CLK_HI_MAX_CYC + 4) @(posedge clk_i);
    #1 check("over high", over, 1'b1);
    check("out held", dout, q[q.size()-1-D]);
    $display("over done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 check("out rst", dout, SDL_OUT_RST);
    t_fill();
    t_recirc();
    t_rest();
    t_over();
    wrap_up();
  end
endmodule
